// File: include/bcc_pkg.sv
// shared types and constants for the branch, call and compare slice
package bcc_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int PC_W = 22;
  localparam int Z_W = 16;
  localparam int EXT_W = 6;
  localparam int REG_IDX_W = 5;
  localparam int IO_AW = 5;
  localparam int BRK_W = 7;
  localparam int BITSEL_W = 3;
  localparam int CNT_W = 3;

  // ------------------------------------------------------------------
  // status flag positions
  // ------------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ------------------------------------------------------------------
  // cycle counts
  // ------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CYC_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [CNT_W-1:0] CYC_IND_CALL_NARROW = 3'h2;
  localparam logic [CNT_W-1:0] CYC_IND_CALL_WIDE = 3'h3;
  localparam logic [CNT_W-1:0] CYC_EXT_CALL = 3'h3;
  localparam logic [CNT_W-1:0] CYC_CALL_NARROW = 3'h3;
  localparam logic [CNT_W-1:0] CYC_CALL_WIDE = 3'h4;
  localparam logic [CNT_W-1:0] CYC_EXIT_NARROW = 3'h4;
  localparam logic [CNT_W-1:0] CYC_EXIT_WIDE = 3'h5;
  localparam logic [CNT_W-1:0] CYC_IO_READ = 3'h1;
  localparam logic [CNT_W-1:0] CYC_NONE = 3'h0;
  localparam logic [CNT_W-1:0] CYC_SKIP_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CYC_SKIP_TWO = 3'h2;

  // ------------------------------------------------------------------
  // program counter steps
  // ------------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_STEP_NEXT = 22'h000001;
  localparam logic [PC_W-1:0] PC_STEP_SKIP1 = 22'h000002;
  localparam logic [PC_W-1:0] PC_STEP_SKIP2 = 22'h000003;
  localparam logic [PC_W-1:0] PC_STEP_LONG = 22'h000002;
  localparam logic [PC_W-Z_W-1:0] PC_HIGH_CLEAR = 6'h00;

  // ------------------------------------------------------------------
  // operations
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE, OP_INDIRECT_SUBROUTINE_JUMP, OP_EXTENDED_INDIRECT_SUBROUTINE_JUMP,
    OP_ABSOLUTE_SUBROUTINE_JUMP, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT,
    OP_COMPARE_SKIP_EQUAL, OP_REGISTER_COMPARE, OP_COMPARE_WITH_CARRY_IN,
    OP_COMPARE_WITH_CONSTANT, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_BIT_SET,
    OP_BRANCH_FLAG_BIT_CLEAR, OP_BRANCH_ZERO_SET, OP_BRANCH_ZERO_CLEAR,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_NOT_LOWER,
    OP_BRANCH_UNSIGNED_LOWER, OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE,
    OP_BRANCH_SIGNED_NOT_LESS, OP_BRANCH_SIGNED_LESS, OP_BRANCH_HALF_CARRY_SET,
    OP_BRANCH_HALF_CARRY_CLEAR, OP_BRANCH_TRANSFER_BIT_SET, OP_BRANCH_TRANSFER_BIT_CLEAR,
    OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR
  } op_t;

  // the irq-state branches and moves do not fit in 32 codes, so they get a sub-op
  typedef enum logic [2:0] {
    SUB_NONE, SUB_BRANCH_IRQ_ENABLED, SUB_BRANCH_IRQ_DISABLED,
    SUB_COPY_REGISTER, SUB_COPY_REGISTER_PAIR, SUB_LOAD_CONSTANT
  } sub_op_t;

  typedef struct packed {
    op_t op;
    sub_op_t sub_op;
    logic [REG_IDX_W-1:0] rd_idx;
    logic [7:0] rd_val;
    logic [15:0] rr_val;
    logic [7:0] imm;
    logic [BITSEL_W-1:0] bit_sel;
    logic [IO_AW-1:0] io_addr;
    logic [BRK_W-1:0] rel_k;
    logic [PC_W-1:0] target;
  } instr_t;

  typedef struct packed {
    logic done;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic push_link;
    logic [PC_W-1:0] link_addr;
    logic stack_pop;
    logic flags_we;
    logic [7:0] flags;
    logic reg_we;
    logic reg_pair;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [15:0] reg_data;
  } result_t;

endpackage

// File: hw/flag_cond_eval.sv
// branch condition evaluation from the status flags
`timescale 1ns/1ns
module flag_cond_eval import bcc_pkg::*; (
  // operation
  input wire op_t op,
  input wire sub_op_t sub_op,
  input wire logic [BITSEL_W-1:0] flag_sel,
  // flags
  input wire logic [7:0] flags,
  // outcome
  output logic is_branch,
  output logic taken
);

  always_comb begin
    is_branch = 1'b1;
    taken = 1'b0;
    unique case (op)
      OP_BRANCH_FLAG_BIT_SET: taken = flags[flag_sel];
      OP_BRANCH_FLAG_BIT_CLEAR: taken = ~flags[flag_sel];
      OP_BRANCH_ZERO_SET: taken = flags[FLAG_Z];
      OP_BRANCH_ZERO_CLEAR: taken = ~flags[FLAG_Z];
      OP_BRANCH_NEGATIVE: taken = flags[FLAG_N];
      OP_BRANCH_POSITIVE: taken = ~flags[FLAG_N];
      OP_BRANCH_CARRY_SET, OP_BRANCH_UNSIGNED_LOWER: taken = flags[FLAG_C];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_NOT_LOWER: taken = ~flags[FLAG_C];
      OP_BRANCH_SIGNED_NOT_LESS: taken = ~(flags[FLAG_N] ^ flags[FLAG_V]);
      OP_BRANCH_SIGNED_LESS: taken = flags[FLAG_N] ^ flags[FLAG_V];
      OP_BRANCH_HALF_CARRY_SET: taken = flags[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: taken = ~flags[FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET: taken = flags[FLAG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR: taken = ~flags[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: taken = flags[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: taken = ~flags[FLAG_V];
      default: begin
        is_branch = 1'b0;
        if (sub_op == SUB_BRANCH_IRQ_ENABLED) begin
          is_branch = 1'b1;
          taken = flags[FLAG_I];
        end else if (sub_op == SUB_BRANCH_IRQ_DISABLED) begin
          is_branch = 1'b1;
          taken = ~flags[FLAG_I];
        end
      end
    endcase
  end

endmodule // flag_cond_eval

// File: hw/branch_call_compare_unit.sv
// control-flow, compare and register-move execution slice
`timescale 1ns/1ns
module branch_call_compare_unit import bcc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // instruction handshake
  input wire logic instr_valid,
  output logic instr_ready,
  input wire instr_t instr,
  // core state
  input wire logic [PC_W-1:0] pc_now,
  input wire logic [Z_W-1:0] z_ptr,
  input wire logic [EXT_W-1:0] extended_indirect_high_byte,
  input wire logic [7:0] status_flags_register,
  input wire logic wide_pc,
  input wire logic next_is_two_word,
  input wire logic [PC_W-1:0] return_pc,
  // io bit read
  output logic io_rd_req,
  output logic [IO_AW-1:0] io_rd_addr,
  input wire logic [7:0] io_rd_data,
  // outcome
  output result_t result
);

  // ------------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IO_WAIT = 2'b01,
    ST_EXEC = 2'b11
  } state_t;

  state_t state;
  logic [CNT_W-1:0] cnt;
  result_t pend;
  result_t next_pend;
  logic [CNT_W-1:0] next_cycles;
  logic next_io;
  logic accept;
  logic br_is;
  logic br_taken;
  logic [BITSEL_W-1:0] io_bit_sel;
  logic io_want_set;
  logic io_two_word;
  logic [PC_W-1:0] io_base_pc;
  logic io_skip;
  logic [CNT_W-1:0] io_extra;
  result_t io_result;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic chain_z,
                                           input logic [7:0] old);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b - {7'h00, cin};
    f = old;
    f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    f[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[FLAG_N] = r[7];
    f[FLAG_S] = r[7] ^ f[FLAG_V];
    // chained compare can only keep Z low, never raise it
    f[FLAG_Z] = (r == 8'h00) & (~chain_z | old[FLAG_Z]);
    return f;
  endfunction

  function automatic logic [PC_W-1:0] skip_step(input logic skip, input logic two_word);
    if (!skip) begin
      return PC_STEP_NEXT;
    end
    return two_word ? PC_STEP_SKIP2 : PC_STEP_SKIP1;
  endfunction

  function automatic logic [CNT_W-1:0] skip_cycles(input logic skip, input logic two_word);
    if (!skip) begin
      return CYC_NONE;
    end
    return two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;
  endfunction

  // ------------------------------------------------------------------
  // branch condition
  // ------------------------------------------------------------------
  flag_cond_eval u_cond (
    .op(instr.op),
    .sub_op(instr.sub_op),
    .flag_sel(instr.bit_sel),
    .flags(status_flags_register),
    .is_branch(br_is),
    .taken(br_taken)
  );

  assign instr_ready = (state == ST_IDLE);
  assign accept = instr_valid & instr_ready;

  // ------------------------------------------------------------------
  // decode at acceptance
  // ------------------------------------------------------------------
  always_comb begin
    next_pend = '0;
    next_pend.done = 1'b1;
    next_pend.pc_load = 1'b1;
    next_pend.pc_value = pc_now + PC_STEP_NEXT;
    next_pend.flags = status_flags_register;
    next_cycles = CYC_ONE;
    next_io = 1'b0;
    unique case (instr.op)
      OP_INDIRECT_SUBROUTINE_JUMP: begin
        next_pend.pc_value = {PC_HIGH_CLEAR, z_ptr};
        next_pend.push_link = 1'b1;
        next_pend.link_addr = pc_now + PC_STEP_NEXT;
        next_cycles = wide_pc ? CYC_IND_CALL_WIDE : CYC_IND_CALL_NARROW;
      end
      OP_EXTENDED_INDIRECT_SUBROUTINE_JUMP: begin
        next_pend.pc_value = {extended_indirect_high_byte, z_ptr};
        next_pend.push_link = 1'b1;
        next_pend.link_addr = pc_now + PC_STEP_NEXT;
        next_cycles = CYC_EXT_CALL;
      end
      OP_ABSOLUTE_SUBROUTINE_JUMP: begin
        next_pend.pc_value = instr.target;
        next_pend.push_link = 1'b1;
        next_pend.link_addr = pc_now + PC_STEP_LONG;
        next_cycles = wide_pc ? CYC_CALL_WIDE : CYC_CALL_NARROW;
      end
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
        next_pend.pc_value = return_pc;
        next_pend.stack_pop = 1'b1;
        next_cycles = wide_pc ? CYC_EXIT_WIDE : CYC_EXIT_NARROW;
        if (instr.op == OP_INTERRUPT_EXIT) begin
          next_pend.flags_we = 1'b1;
          next_pend.flags[FLAG_I] = 1'b1;
        end
      end
      OP_COMPARE_SKIP_EQUAL: begin
        next_pend.pc_value = pc_now + skip_step(instr.rd_val == instr.rr_val[7:0],
                                                next_is_two_word);
        next_cycles = CYC_ONE + skip_cycles(instr.rd_val == instr.rr_val[7:0],
                                            next_is_two_word);
      end
      OP_REGISTER_COMPARE: begin
        next_pend.flags_we = 1'b1;
        next_pend.flags = cmp_flags(instr.rd_val, instr.rr_val[7:0], 1'b0, 1'b0,
                                    status_flags_register);
      end
      OP_COMPARE_WITH_CARRY_IN: begin
        next_pend.flags_we = 1'b1;
        next_pend.flags = cmp_flags(instr.rd_val, instr.rr_val[7:0],
                                    status_flags_register[FLAG_C], 1'b1,
                                    status_flags_register);
      end
      OP_COMPARE_WITH_CONSTANT: begin
        next_pend.flags_we = 1'b1;
        next_pend.flags = cmp_flags(instr.rd_val, instr.imm, 1'b0, 1'b0,
                                    status_flags_register);
      end
      OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET: begin
        next_pend.pc_value = pc_now + skip_step(
          instr.rr_val[instr.bit_sel] == (instr.op == OP_SKIP_REG_BIT_SET),
          next_is_two_word);
        next_cycles = CYC_ONE + skip_cycles(
          instr.rr_val[instr.bit_sel] == (instr.op == OP_SKIP_REG_BIT_SET),
          next_is_two_word);
      end
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
        next_io = 1'b1;
        next_cycles = CYC_ONE + CYC_IO_READ;
      end
      default: begin
        if (br_is) begin
          if (br_taken) begin
            next_pend.pc_value = pc_now + PC_STEP_NEXT +
              {{(PC_W-BRK_W){instr.rel_k[BRK_W-1]}}, instr.rel_k};
            next_cycles = CYC_BR_TAKEN;
          end
        end else begin
          unique case (instr.sub_op)
            SUB_COPY_REGISTER: begin
              next_pend.reg_we = 1'b1;
              next_pend.reg_data = {8'h00, instr.rr_val[7:0]};
            end
            SUB_COPY_REGISTER_PAIR: begin
              next_pend.reg_we = 1'b1;
              next_pend.reg_pair = 1'b1;
              next_pend.reg_data = instr.rr_val;
            end
            SUB_LOAD_CONSTANT: begin
              next_pend.reg_we = 1'b1;
              next_pend.reg_data = {8'h00, instr.imm};
            end
            default: begin
            end
          endcase
          next_pend.reg_idx = instr.rd_idx;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // io bit resolution
  // ------------------------------------------------------------------
  // the io word is taken in the cycle the request is high, one after acceptance, so the skip
  // decision costs that cycle on top of the register-bit variant
  always_comb begin
    io_skip = (io_rd_data[io_bit_sel] == io_want_set);
    io_extra = skip_cycles(io_skip, io_two_word);
    io_result = pend;
    io_result.pc_value = io_base_pc + skip_step(io_skip, io_two_word);
  end

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept && next_io) begin
            state <= ST_IO_WAIT;
          end else if (accept && next_cycles != CYC_ONE) begin
            state <= ST_EXEC;
          end
        end
        ST_IO_WAIT: state <= (io_extra == CYC_NONE) ? ST_IDLE : ST_EXEC;
        ST_EXEC: begin
          if (cnt == CYC_ONE) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt <= CYC_NONE;
    end else if (accept) begin
      cnt <= next_cycles - CYC_ONE;
    end else if (state == ST_IO_WAIT) begin
      cnt <= io_extra;
    end else if (state == ST_EXEC) begin
      cnt <= cnt - CYC_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pend <= '0;
      io_bit_sel <= '0;
      io_want_set <= 1'b0;
      io_two_word <= 1'b0;
      io_base_pc <= '0;
    end else if (accept) begin
      pend <= next_pend;
      io_bit_sel <= instr.bit_sel;
      io_want_set <= (instr.op == OP_SKIP_IO_BIT_SET);
      io_two_word <= next_is_two_word;
      io_base_pc <= pc_now;
    end else if (state == ST_IO_WAIT) begin
      pend <= io_result;
    end
  end

  // ------------------------------------------------------------------
  // io request
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      io_rd_req <= 1'b0;
      io_rd_addr <= '0;
    end else begin
      io_rd_req <= accept & next_io;
      if (accept && next_io) begin
        io_rd_addr <= instr.io_addr;
      end
    end
  end

  // ------------------------------------------------------------------
  // outcome register
  // ------------------------------------------------------------------
  // fields are meaningful only while done is high; zeroed otherwise so a
  // stray write enable can never reach the core
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      result <= '0;
    end else if (accept && !next_io && next_cycles == CYC_ONE) begin
      result <= next_pend;
    end else if (state == ST_IO_WAIT && io_extra == CYC_NONE) begin
      result <= io_result;
    end else if (state == ST_EXEC && cnt == CYC_ONE) begin
      result <= pend;
    end else begin
      result <= '0;
    end
  end

endmodule // branch_call_compare_unit

// File: sim/bcc_asserts.sv
// port-level assertions for the branch, call and compare slice
`timescale 1ns/1ns
module bcc_asserts import bcc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // instruction handshake
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire instr_t instr,
  // core state
  input wire logic [PC_W-1:0] pc_now,
  input wire logic [Z_W-1:0] z_ptr,
  input wire logic [EXT_W-1:0] extended_indirect_high_byte,
  input wire logic [7:0] status_flags_register,
  input wire logic wide_pc,
  input wire logic next_is_two_word,
  input wire logic [PC_W-1:0] return_pc,
  // io bit read
  input wire logic io_rd_req,
  input wire logic [IO_AW-1:0] io_rd_addr,
  input wire logic [7:0] io_rd_data,
  // outcome
  input wire result_t result
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  logic io_op;
  assign acc = instr_valid && instr_ready;
  assign io_op = instr.op == OP_SKIP_IO_BIT_CLEAR || instr.op == OP_SKIP_IO_BIT_SET;

  chk_ind_call_narrow: assert property (acc && instr.op == OP_INDIRECT_SUBROUTINE_JUMP && !wide_pc
    |=> !result.done ##1 (result.done && result.pc_value == {PC_HIGH_CLEAR, $past(z_ptr, 2)}))
    else $error("indirect call target or timing wrong");
  chk_ext_call_target: assert property (acc && instr.op == OP_EXTENDED_INDIRECT_SUBROUTINE_JUMP
    |=> !result.done [*2] ##1 (result.done
    && result.pc_value == {$past(extended_indirect_high_byte, 3), $past(z_ptr, 3)}))
    else $error("extended indirect call target or timing wrong");
  chk_irq_exit_flag: assert property (result.done && result.stack_pop && result.flags_we
    |-> result.flags[FLAG_I]) else $error("interrupt exit left global flag clear");
  chk_cmp_one_cycle: assert property (acc && instr.op inside {OP_REGISTER_COMPARE,
    OP_COMPARE_WITH_CARRY_IN, OP_COMPARE_WITH_CONSTANT}
    |=> result.done && result.flags_we && !result.reg_we) else $error("compare result wrong");
  chk_io_read_req: assert property (acc && io_op
    |=> io_rd_req && !result.done && io_rd_addr == $past(instr.io_addr))
    else $error("io skip read request wrong");
  chk_skip_eq_flags: assert property (acc && instr.op == OP_COMPARE_SKIP_EQUAL
    |=> (!result.flags_we && !result.reg_we) [*3]) else $error("compare skip wrote flags");
  chk_move_one_cycle: assert property (acc && instr.op == OP_NONE && instr.sub_op inside
    {SUB_COPY_REGISTER, SUB_COPY_REGISTER_PAIR, SUB_LOAD_CONSTANT}
    |=> result.done && result.reg_we && !result.flags_we) else $error("move result wrong");
  chk_branch_timing: assert property (acc && instr.op >= OP_BRANCH_FLAG_BIT_SET
    |=> (result.done && !result.flags_we && result.pc_value == $past(pc_now) + PC_STEP_NEXT)
    or (!result.done ##1 (result.done && !result.flags_we))) else $error("branch timing wrong");
endmodule // bcc_asserts

bind branch_call_compare_unit bcc_asserts u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr), .pc_now(pc_now),
  .z_ptr(z_ptr), .extended_indirect_high_byte(extended_indirect_high_byte),
  .status_flags_register(status_flags_register), .wide_pc(wide_pc),
  .next_is_two_word(next_is_two_word), .return_pc(return_pc), .io_rd_req(io_rd_req),
  .io_rd_addr(io_rd_addr), .io_rd_data(io_rd_data), .result(result));

// File: sim/testbench.sv
// self-checking testbench for the branch, call and compare slice
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module testbench import bcc_pkg::*; ;
  localparam logic [PC_W-1:0] PC0 = 22'h000100;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic instr_ready;
  instr_t instr = '0;
  logic [PC_W-1:0] pc_now = PC0;
  logic [Z_W-1:0] z_ptr = 16'hBEEF;
  logic [EXT_W-1:0] ext_hi = 6'h2A;
  logic [7:0] status_flags_register = 8'h00;
  logic wide_pc = 1'b0;
  logic next_is_two_word = 1'b0;
  logic [PC_W-1:0] return_pc = 22'h155AAA;
  logic io_rd_req;
  logic [IO_AW-1:0] io_rd_addr;
  logic [7:0] io_rd_data;
  logic [7:0] io_byte = 8'h00;
  result_t result;
  result_t res;
  int cyc;
  int errors = 0;
  int n_checks = 0;
  // the io byte only stands while requested; otherwise it is inverted
  assign io_rd_data = io_rd_req ? io_byte : ~io_byte;

  branch_call_compare_unit DUT (.sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .pc_now(pc_now), .z_ptr(z_ptr),
    .extended_indirect_high_byte(ext_hi), .status_flags_register(status_flags_register),
    .wide_pc(wide_pc), .next_is_two_word(next_is_two_word), .return_pc(return_pc),
    .io_rd_req(io_rd_req), .io_rd_addr(io_rd_addr), .io_rd_data(io_rd_data), .result(result));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // entered in the time step of an edge; returns at the done edge
  task automatic run(input instr_t i);
    instr <= i;
    instr_valid <= 1'b1;
    cyc = 0;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      cyc++;
    end while (result.done !== 1'b1 && cyc < 8);
    res = result;
  endtask

  function automatic logic [7:0] cmp_flags(logic [7:0] sr, logic [7:0] d, logic [7:0] r, logic ci, logic ch);
    logic [7:0] q;
    logic [7:0] f;
    q = d - r - {7'h00, ci};
    f = sr;
    f[FLAG_H] = (~d[3] & r[3]) | (r[3] & q[3]) | (q[3] & ~d[3]);
    f[FLAG_C] = (~d[7] & r[7]) | (r[7] & q[7]) | (q[7] & ~d[7]);
    f[FLAG_V] = (d[7] & ~r[7] & ~q[7]) | (~d[7] & r[7] & q[7]);
    f[FLAG_N] = q[7];
    f[FLAG_S] = q[7] ^ f[FLAG_V];
    f[FLAG_Z] = (q == 8'h00) & (!ch | sr[FLAG_Z]);
    return f;
  endfunction

  // branch index in enum order, pairs of set and cleared forms
  function automatic logic taken(int x, logic [7:0] f, logic [2:0] s);
    logic b;
    case (x / 2)
      0: b = f[s];
      1: b = f[FLAG_Z];
      2: b = f[FLAG_C];
      3: b = !f[FLAG_C];
      4: b = f[FLAG_N];
      5: b = !(f[FLAG_N] ^ f[FLAG_V]);
      6: b = f[FLAG_H];
      7: b = f[FLAG_T];
      8: b = f[FLAG_V];
      default: b = f[FLAG_I];
    endcase
    return x[0] ? !b : b;
  endfunction

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_calls();
    instr_t i;
    for (int w = 0; w < 2; w++) begin
      wide_pc <= w[0];
      status_flags_register <= 8'h21;
      i = '0;
      i.op = OP_INDIRECT_SUBROUTINE_JUMP;
      run(i);
      `CHK(cyc, w + 2)
      `CHK(res.pc_value, {6'h00, 16'hBEEF})
      `CHK({res.push_link, res.link_addr, res.flags_we}, {1'b1, PC0 + 22'h000001, 1'b0})
      i.op = OP_EXTENDED_INDIRECT_SUBROUTINE_JUMP;
      run(i);
      `CHK(cyc, 3)
      `CHK({res.pc_value, res.flags_we}, {6'h2A, 16'hBEEF, 1'b0})
      i.op = OP_ABSOLUTE_SUBROUTINE_JUMP;
      i.target = 22'h2ABCDE;
      run(i);
      `CHK(cyc, w + 3)
      `CHK({res.pc_value, res.push_link, res.link_addr}, {22'h2ABCDE, 1'b1, PC0 + 22'h000002})
      for (int e = 0; e < 2; e++) begin
        i.op = e ? OP_INTERRUPT_EXIT : OP_SUBROUTINE_EXIT;
        run(i);
        `CHK(cyc, w + 4)
        `CHK({res.pc_value, res.stack_pop, res.flags_we}, {22'h155AAA, 1'b1, e[0]})
        if (e == 1) `CHK(res.flags, 8'hA1)
      end
    end
    wide_pc <= 1'b0;
    $display("test calls finished");
  endtask

  task automatic t_compare();
    instr_t i;
    logic [7:0] sr;
    logic [7:0] dv [5] = '{8'h10, 8'h00, 8'h80, 8'h7F, 8'h38};
    logic [7:0] rv [5] = '{8'h10, 8'h01, 8'h01, 8'hFF, 8'h09};
    for (int o = 0; o < 3; o++) for (int p = 0; p < 5; p++) begin
      sr = p[0] ? 8'h03 : 8'h40;
      status_flags_register <= sr;
      i = '0;
      i.op = op_t'(OP_REGISTER_COMPARE + o);
      i.rd_val = dv[p];
      i.rr_val = {8'h00, (o == 2) ? ~rv[p] : rv[p]};
      i.imm = (o == 2) ? rv[p] : ~rv[p];
      run(i);
      `CHK(cyc, 1)
      `CHK({res.flags_we, res.reg_we}, 2'h2)
      `CHK(res.flags, cmp_flags(sr, dv[p], rv[p], (o == 1) & sr[FLAG_C], o == 1))
    end
    $display("test compare finished");
  endtask

  task automatic t_skip();
    instr_t i;
    logic [7:0] pat;
    logic sk;
    int st;
    for (int k = 0; k < 5; k++) for (int v = 0; v < 2; v++) for (int tw = 0; tw < 2; tw++) begin
      i = '0;
      i.op = (k == 0) ? OP_COMPARE_SKIP_EQUAL : op_t'(OP_SKIP_REG_BIT_CLEAR + k - 1);
      i.bit_sel = 3'(k + 2 * v + tw);
      pat = v ? (8'h01 << i.bit_sel) : ~(8'h01 << i.bit_sel);
      i.rd_val = 8'h5C;
      i.rr_val = (k == 0) ? {8'h00, v ? 8'h5C : 8'h5D} : {8'h00, pat};
      i.io_addr = 5'(k * 7 + v);
      io_byte <= pat;
      next_is_two_word <= tw[0];
      sk = (k == 1 || k == 3) ? !v[0] : v[0];
      st = sk ? tw + 2 : 1;
      run(i);
      `CHK(cyc, st + (k >= 3))
      `CHK(res.pc_value, PC0 + 22'(st))
      `CHK(res.flags_we, 1'b0)
    end
    $display("test skip finished");
  endtask

  task automatic t_branch();
    instr_t i;
    logic tk;
    logic [7:0] sv [5] = '{8'h00, 8'hFF, 8'h04, 8'h08, 8'h6A};
    logic [6:0] kv [5] = '{7'h05, 7'h7E, 7'h3F, 7'h40, 7'h00};
    for (int j = 0; j < 5; j++) for (int x = 0; x < 20; x++) begin
      i = '0;
      i.op = (x < 18) ? op_t'(OP_BRANCH_FLAG_BIT_SET + x) : OP_NONE;
      i.sub_op = (x < 18) ? SUB_NONE : sub_op_t'(SUB_BRANCH_IRQ_ENABLED + x - 18);
      i.bit_sel = 3'(j * 3 + x);
      i.rel_k = kv[j];
      status_flags_register <= sv[j];
      tk = taken(x, sv[j], i.bit_sel);
      run(i);
      `CHK(cyc, tk ? 2 : 1)
      `CHK(res.pc_value, PC0 + 22'h000001 + (tk ? {{15{kv[j][6]}}, kv[j]} : 22'h000000))
      `CHK({res.pc_load, res.flags_we}, 2'h2)
    end
    $display("test branch finished");
  endtask

  task automatic t_move();
    instr_t i;
    for (int m = 0; m < 3; m++) begin
      i = '0;
      i.sub_op = sub_op_t'(SUB_COPY_REGISTER + m);
      i.rd_idx = 5'h1A;
      i.rd_val = 8'h11;
      i.rr_val = 16'hC35A;
      i.imm = 8'h96;
      run(i);
      `CHK(cyc, 1)
      `CHK({res.reg_we, res.reg_idx, res.flags_we, res.reg_pair}, {1'b1, 5'h1A, 1'b0, m == 1})
      `CHK(res.reg_data[7:0], (m == 2) ? 8'h96 : 8'h5A)
      if (m == 1) `CHK(res.reg_data, 16'hC35A)
    end
    $display("test move finished");
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------------
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    #5000000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    `CHK({instr_ready, io_rd_req, result}, {2'h2, {$bits(result_t){1'b0}}})
    resetn <= 1'b1;
    t_calls();
    t_compare();
    t_skip();
    t_branch();
    t_move();
    give_verdict();
  end
endmodule // testbench
